//--- hdl/ppmce_pkg.sv
package ppmce_pkg;

  // Register bus geometry.
  localparam int unsigned BUS_DW = 32;               // Data width of the register bus.
  localparam int unsigned BUS_AW = 8;                // Byte address width of the register bus.
  localparam int unsigned BUS_BE = BUS_DW / 8;       // Byte enables per word.

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL     = 8'h00;       // Mode and reporting controls.
  localparam logic [7:0] OFS_FUNC_EN  = 8'h04;       // Per-function enable bits.
  localparam logic [7:0] OFS_AER_COR  = 8'h08;       // Per-function corrected internal error status.
  localparam logic [7:0] OFS_DEV_STAT = 8'h0C;       // Per-function correctable error detected status.
  localparam logic [7:0] OFS_LINK_CAP = 8'h10;       // Link capabilities, read only.
  localparam logic [7:0] OFS_PM_STAT  = 8'h14;       // Power change handshake status, read only.

  // Control register fields and reset value.
  localparam int unsigned CTRL_EP_MODE_BIT  = 0;     // Endpoint mode enable.
  localparam int unsigned CTRL_MSG_EN_BIT   = 1;     // Correctable error message signaling enable.
  localparam int unsigned CTRL_COR_MASK_BIT = 2;     // Mask for the corrected internal error.
  localparam int unsigned CTRL_W            = 3;     // Implemented control bits.
  localparam logic [2:0]  CTRL_RESET        = 3'h1;  // Endpoint mode, messages off, unmasked.

  // Link capabilities field placement.
  localparam int unsigned LINK_CAP_PORT_LSB = 24;    // Port number sits in the top byte.

  // Power handshake status fields.
  localparam int unsigned PM_REQ_BIT    = 0;         // Change request pending.
  localparam int unsigned PM_VF_BIT     = 1;         // Pending target is a virtual function.
  localparam int unsigned PM_STATE_LSB  = 2;         // Pending target state, two bits.
  localparam int unsigned PM_FUNC_LSB   = 8;         // Pending function number, eight bits.

  // Power state encodings as carried in the power management control field.
  localparam logic [1:0] DSTATE_D0 = 2'h0;           // Fully on.
  localparam logic [1:0] DSTATE_D1 = 2'h1;           // Light sleep.
  localparam logic [1:0] DSTATE_D2 = 2'h2;           // Deeper sleep.
  localparam logic [1:0] DSTATE_D3 = 2'h3;           // Hot off.

  // Handshake sequencer states.
  typedef enum logic [0:0] {
    PS_IDLE,
    PS_WAIT_ACK
  } ppmce_pm_state_t;

endpackage

//--- hdl/ppmce_dstate_bank.sv
// Holds the current power state of a set of functions, one two-bit entry each.
module ppmce_dstate_bank
  import ppmce_pkg::*;
#(
  parameter int unsigned COUNT = 4                   // Number of functions held.
) (
  input  wire logic                 clk_in,          // Core clock.
  input  wire logic                 rst_in,          // Asynchronous reset, active high.
  input  wire logic                 we_in,           // Write strobe, one cycle.
  input  wire logic [7:0]           idx_in,          // Function number to update.
  input  wire logic [1:0]           val_in,          // New power state.
  output logic      [2*COUNT-1:0]   state_out        // All states, entry i at bits 2i+1:2i.
);

  if (COUNT < 1 || COUNT > 256) begin : g_bad_count
    $error("COUNT must lie between 1 and 256.");
  end

  logic [2*COUNT-1:0] state_q;                       // Registered states.
  logic [2*COUNT-1:0] state_d;                       // Next states.

  // An out-of-range function number leaves every entry untouched.
  always_comb begin
    state_d = state_q;
    for (int i = 0; i < COUNT; i++) begin
      if (we_in && (idx_in == 8'(i))) begin
        state_d[2*i +: 2] = val_in;
      end
    end
  end

  // Every function comes out of reset in D0.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= {COUNT{DSTATE_D0}};
    end else begin
      state_q <= state_d;
    end
  end

  assign state_out = state_q;

endmodule

//--- hdl/ppmce_ctrl.sv
// Power state change handshake and correctable error reporting, with an Avalon-MM register slave.
//
// Decided for this implementation: register access over Avalon-MM and the address map.
module ppmce_ctrl
  import ppmce_pkg::*;
#(
  parameter int unsigned NUM_PF       = 4,           // Physical functions.
  parameter int unsigned NUM_VF       = 8,           // Virtual functions.
  parameter logic [23:0] LINK_CAP_LOW = 24'h000000   // Link capability bits below the port number.
) (
  input  wire logic                  SYS_CLK_IN,          // Core clock, 20 MHz.
  input  wire logic                  RST_IN,              // Asynchronous reset, active high.
  // Register bus.
  input  wire logic [BUS_AW-1:0]     AVS_ADDRESS_IN,      // Byte address.
  input  wire logic                  AVS_READ_IN,         // Read request.
  input  wire logic                  AVS_WRITE_IN,        // Write request.
  input  wire logic [BUS_DW-1:0]     AVS_WRITEDATA_IN,    // Write data.
  input  wire logic [BUS_BE-1:0]     AVS_BYTEENABLE_IN,   // Write byte lanes.
  output logic      [BUS_DW-1:0]     AVS_READDATA_OUT,    // Read data.
  output logic                       AVS_WAITREQUEST_OUT, // Slave stall.
  // Configuration engine side.
  input  wire logic                  CFG_PM_WR_IN,        // Power control field written, one cycle.
  input  wire logic [7:0]            CFG_PM_FUNC_IN,      // Function number of that write.
  input  wire logic                  CFG_PM_IS_VF_IN,     // That write targets a virtual function.
  input  wire logic [1:0]            CFG_PM_DSTATE_IN,    // Power state written.
  output logic                       CFG_CPL_HOLD_OUT,    // Completions must be withheld.
  input  wire logic [NUM_PF-1:0]     CORE_COR_ERR_IN,     // Core-detected correctable error per PF.
  // User application side.
  output logic                       PM_CHANGE_REQ_OUT,   // Power state change request.
  input  wire logic                  PM_CHANGE_ACK_IN,    // User acknowledge.
  output logic      [7:0]            EXT_FUNC_NUM_OUT,    // Function under change.
  output logic      [2*NUM_PF-1:0]   PF_DSTATE_OUT,       // Physical function power states.
  output logic      [2*NUM_VF-1:0]   VF_DSTATE_OUT,       // Virtual function power states.
  input  wire logic [7:0]            LINK_CAP_PORT_NUM_IN,// Port number for link capabilities.
  input  wire logic                  ERR_COR_IN,          // User correctable error, one cycle.
  output logic                       ERR_COR_DET_OUT,     // Correctable error detected, one cycle.
  output logic                       ERR_COR_MSG_OUT      // Correctable error message send, one cycle.
);

  // Refuse counts the registers cannot carry.
  if (NUM_PF < 1 || NUM_PF > BUS_DW) begin : g_bad_pf
    $error("NUM_PF must lie between 1 and the bus width.");
  end
  if (NUM_VF < 1 || NUM_VF > 256) begin : g_bad_vf
    $error("NUM_VF must lie between 1 and 256.");
  end

  // Merges write data into an old value by byte lane.
  function automatic logic [BUS_DW-1:0] be_merge(input logic [BUS_DW-1:0] old_v,
                                                 input logic [BUS_DW-1:0] new_v,
                                                 input logic [BUS_BE-1:0] be);
    logic [BUS_DW-1:0] res;
    res = old_v;
    for (int b = 0; b < BUS_BE; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Widens a per-function vector to a bus word, upper bits zero.
  function automatic logic [BUS_DW-1:0] pf_word(input logic [NUM_PF-1:0] v);
    logic [BUS_DW-1:0] res;
    res = '0;
    res[NUM_PF-1:0] = v;
    return res;
  endfunction

  // Handshake state.
  ppmce_pm_state_t   ps_q;                           // Sequencer state.
  ppmce_pm_state_t   ps_d;                           // Next sequencer state.
  logic [7:0]        pend_func_q;                    // Function awaiting acknowledge.
  logic [7:0]        pend_func_d;                    // Next pending function.
  logic              pend_vf_q;                      // Pending target is virtual.
  logic              pend_vf_d;                      // Next pending kind.
  logic [1:0]        pend_state_q;                   // Pending target state.
  logic [1:0]        pend_state_d;                   // Next pending target state.
  logic              req_q;                          // Registered change request.
  logic              req_d;                          // Next change request.
  logic              hold_q;                         // Registered completion hold.
  logic              pf_we;                          // Physical state bank write.
  logic              vf_we;                          // Virtual state bank write.
  logic [7:0]        bank_idx;                       // Bank write function number.
  logic [1:0]        bank_val;                       // Bank write state.

  // Error reporting state.
  logic [CTRL_W-1:0] ctrl_q;                         // Control register.
  logic [CTRL_W-1:0] ctrl_d;                         // Next control value.
  logic [NUM_PF-1:0] func_en_q;                      // Function enables.
  logic [NUM_PF-1:0] func_en_d;                      // Next function enables.
  logic [NUM_PF-1:0] aer_cor_q;                      // Corrected internal error status.
  logic [NUM_PF-1:0] aer_cor_d;                      // Next corrected internal error status.
  logic [NUM_PF-1:0] dev_stat_q;                     // Correctable error detected status.
  logic [NUM_PF-1:0] dev_stat_d;                     // Next detected status.
  logic              det_q;                          // Registered detect pulse.
  logic              det_d;                          // Next detect pulse.
  logic              msg_q;                          // Registered message pulse.
  logic              msg_d;                          // Next message pulse.
  logic [NUM_PF-1:0] user_hit;                       // Functions touched by a user error.
  logic [NUM_PF-1:0] core_hit;                       // Functions touched by a core error.
  logic [NUM_PF-1:0] reported;                       // Unmasked new errors per function.
  logic [BUS_DW-1:0] ctrl_wr;                        // Control word after a write merge.
  logic [BUS_DW-1:0] func_en_wr;                     // Enable word after a write merge.

  // Bus state.
  logic              wait_q;                         // Registered waitrequest.
  logic              wait_d;                         // Next waitrequest.
  logic [BUS_DW-1:0] rdata_q;                        // Registered read data.
  logic [BUS_DW-1:0] rdata_d;                        // Next read data.
  logic              wr_fire;                        // Write completes this cycle.
  logic [BUS_DW-1:0] wr_word;                        // Write data gated by byte lanes.
  logic [BUS_DW-1:0] link_cap;                       // Link capabilities word.
  logic [BUS_DW-1:0] pm_stat;                        // Handshake status word.

  // Handshake sequencer: D1 and D3 wait for the user, D0 and D2 apply at once.
  always_comb begin
    ps_d         = ps_q;
    pend_func_d  = pend_func_q;
    pend_vf_d    = pend_vf_q;
    pend_state_d = pend_state_q;
    pf_we        = 1'b0;
    vf_we        = 1'b0;
    bank_idx     = CFG_PM_FUNC_IN;
    bank_val     = CFG_PM_DSTATE_IN;
    unique case (ps_q)
      // Idle: look at each power control write as it arrives.
      PS_IDLE: begin
        if (CFG_PM_WR_IN) begin
          if (CFG_PM_DSTATE_IN == DSTATE_D1 || CFG_PM_DSTATE_IN == DSTATE_D3) begin
            ps_d         = PS_WAIT_ACK;
            pend_func_d  = CFG_PM_FUNC_IN;
            pend_vf_d    = CFG_PM_IS_VF_IN;
            pend_state_d = CFG_PM_DSTATE_IN;
          end else begin
            // D0 or D2, so the user need not be asked.
            pf_we = ~CFG_PM_IS_VF_IN;
            vf_we = CFG_PM_IS_VF_IN;
          end
        end
      end
      // Waiting: further writes are ignored until the user answers.
      PS_WAIT_ACK: begin
        // The bank is written from the captured request, not the live inputs.
        bank_idx = pend_func_q;
        bank_val = pend_state_q;
        if (PM_CHANGE_ACK_IN) begin
          ps_d  = PS_IDLE;
          pf_we = ~pend_vf_q;
          vf_we = pend_vf_q;
        end
      end
    endcase
    // The request is decoded from the state, so it cannot drop before the answer.
    req_d = (ps_d == PS_WAIT_ACK);
  end

  // Registers the handshake; the hold follows the request cycle for cycle.
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      // Idle, no request pending, nothing withheld.
      ps_q         <= PS_IDLE;
      pend_func_q  <= 8'h00;
      pend_vf_q    <= 1'b0;
      pend_state_q <= DSTATE_D0;
      req_q        <= 1'b0;
      hold_q       <= 1'b0;
    end else begin
      ps_q         <= ps_d;
      pend_func_q  <= pend_func_d;
      pend_vf_q    <= pend_vf_d;
      pend_state_q <= pend_state_d;
      req_q        <= req_d;
      hold_q       <= req_d;
    end
  end

  // Physical function power states.
  ppmce_dstate_bank #(
    .COUNT     (NUM_PF)
  ) u_pf_bank (
    .clk_in    (SYS_CLK_IN),
    .rst_in    (RST_IN),
    .we_in     (pf_we),
    .idx_in    (bank_idx),
    .val_in    (bank_val),
    .state_out (PF_DSTATE_OUT)
  );

  // Virtual function power states.
  ppmce_dstate_bank #(
    .COUNT     (NUM_VF)
  ) u_vf_bank (
    .clk_in    (SYS_CLK_IN),
    .rst_in    (RST_IN),
    .we_in     (vf_we),
    .idx_in    (bank_idx),
    .val_in    (bank_val),
    .state_out (VF_DSTATE_OUT)
  );

  // Register slave: one wait cycle, then the answer; writes act on the answer edge.
  always_comb begin
    wait_d   = 1'b1;
    rdata_d  = rdata_q;
    wr_fire  = AVS_WRITE_IN && !wait_q;
    wr_word  = be_merge('0, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
    link_cap = {LINK_CAP_PORT_NUM_IN, LINK_CAP_LOW};
    // The status word shows the pending handshake to software.
    pm_stat  = '0;
    pm_stat[PM_REQ_BIT]            = req_q;
    pm_stat[PM_VF_BIT]             = pend_vf_q;
    pm_stat[PM_STATE_LSB +: 2]     = pend_state_q;
    pm_stat[PM_FUNC_LSB +: 8]      = pend_func_q;
    // Answer only from the stalled state, so each access gets one wait cycle.
    if ((AVS_READ_IN || AVS_WRITE_IN) && wait_q) begin
      wait_d = 1'b0;
      // Read data is captured here and stands until the next read.
      if (AVS_READ_IN) begin
        unique case (AVS_ADDRESS_IN)
          OFS_CTRL:     rdata_d = BUS_DW'(ctrl_q);
          OFS_FUNC_EN:  rdata_d = pf_word(func_en_q);
          OFS_AER_COR:  rdata_d = pf_word(aer_cor_q);
          OFS_DEV_STAT: rdata_d = pf_word(dev_stat_q);
          OFS_LINK_CAP: rdata_d = link_cap;
          OFS_PM_STAT:  rdata_d = pm_stat;
          default:      rdata_d = '0;                 // Unmapped reads return zero.
        endcase
      end
    end
  end

  // Error reporting and control registers; hardware sets win over software clears.
  always_comb begin
    ctrl_d     = ctrl_q;
    func_en_d  = func_en_q;
    // A user error touches every enabled function alike, never one alone.
    user_hit   = ERR_COR_IN ? func_en_q : '0;
    // A core error touches only the function that saw it, if enabled.
    core_hit   = CORE_COR_ERR_IN & func_en_q;
    // Merge the write into whole words first, then keep the implemented bits.
    ctrl_wr    = be_merge(BUS_DW'(ctrl_q), AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
    func_en_wr = be_merge(pf_word(func_en_q), AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
    if (wr_fire && AVS_ADDRESS_IN == OFS_CTRL) begin
      // Software changes mode, message enable and mask together.
      ctrl_d = ctrl_wr[CTRL_W-1:0];
    end
    if (wr_fire && AVS_ADDRESS_IN == OFS_FUNC_EN) begin
      // Disabled functions neither log status nor count for messages.
      func_en_d = func_en_wr[NUM_PF-1:0];
    end
    aer_cor_d  = aer_cor_q;
    dev_stat_d = dev_stat_q;
    if (wr_fire && AVS_ADDRESS_IN == OFS_AER_COR) begin
      aer_cor_d = aer_cor_q & ~wr_word[NUM_PF-1:0];   // Write one to clear.
    end
    if (wr_fire && AVS_ADDRESS_IN == OFS_DEV_STAT) begin
      dev_stat_d = dev_stat_q & ~wr_word[NUM_PF-1:0]; // Write one to clear.
    end
    // Sets are applied after clears, so a set in the same cycle wins.
    aer_cor_d  = aer_cor_d | user_hit;
    dev_stat_d = dev_stat_d | user_hit | core_hit;
    // A masked internal error still logs status but is not signaled.
    reported   = (ctrl_q[CTRL_COR_MASK_BIT] ? '0 : user_hit) | core_hit;
    det_d      = ctrl_q[CTRL_EP_MODE_BIT] && (|reported);
    // One message for the whole device, never one per function.
    msg_d      = ERR_COR_IN && (|func_en_q) && !ctrl_q[CTRL_COR_MASK_BIT]
                 && ctrl_q[CTRL_MSG_EN_BIT];
  end

  // Registers the bus answer, controls, status and error pulses.
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wait_q     <= 1'b1;
      rdata_q    <= '0;
      ctrl_q     <= CTRL_RESET;
      // Every function starts enabled.
      func_en_q  <= '1;
      aer_cor_q  <= '0;
      dev_stat_q <= '0;
      det_q      <= 1'b0;
      msg_q      <= 1'b0;
    end else begin
      wait_q     <= wait_d;
      rdata_q    <= rdata_d;
      ctrl_q     <= ctrl_d;
      func_en_q  <= func_en_d;
      aer_cor_q  <= aer_cor_d;
      dev_stat_q <= dev_stat_d;
      det_q      <= det_d;
      msg_q      <= msg_d;
    end
  end

  // Outputs come straight from flip-flops.
  assign AVS_READDATA_OUT    = rdata_q;
  assign AVS_WAITREQUEST_OUT = wait_q;
  // The hold is a registered copy of the request, so both change on one edge.
  assign CFG_CPL_HOLD_OUT    = hold_q;
  assign PM_CHANGE_REQ_OUT   = req_q;
  assign EXT_FUNC_NUM_OUT    = pend_func_q;
  assign ERR_COR_DET_OUT     = det_q;
  assign ERR_COR_MSG_OUT     = msg_q;

endmodule

//--- sim/ppmce_checker.sv
// Watches the handshake and error pulses at the top module's ports.
module ppmce_checker
  import ppmce_pkg::*;
#(
  parameter int unsigned NUM_PF = 4                    // Physical functions.
) (
  input wire logic                SYS_CLK_IN,          // Core clock.
  input wire logic                RST_IN,              // Reset, active high.
  input wire logic                CFG_PM_WR_IN,        // Power write pulse.
  input wire logic [7:0]          CFG_PM_FUNC_IN,      // Function of that write.
  input wire logic [1:0]          CFG_PM_DSTATE_IN,    // State written.
  input wire logic                CFG_CPL_HOLD_OUT,    // Completion hold.
  input wire logic [NUM_PF-1:0]   CORE_COR_ERR_IN,     // Core errors.
  input wire logic                PM_CHANGE_REQ_OUT,   // Change request.
  input wire logic                PM_CHANGE_ACK_IN,    // User acknowledge.
  input wire logic [7:0]          EXT_FUNC_NUM_OUT,    // Function under change.
  input wire logic [2*NUM_PF-1:0] PF_DSTATE_OUT,       // PF states.
  input wire logic                ERR_COR_IN,          // User error pulse.
  input wire logic                ERR_COR_DET_OUT,     // Detect pulse.
  input wire logic                ERR_COR_MSG_OUT      // Message pulse.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  // A power write accepted while the sequencer is idle.
  sequence s_take; CFG_PM_WR_IN && !PM_CHANGE_REQ_OUT; endsequence
  // The acknowledge seen while a request stands.
  sequence s_ack; PM_CHANGE_REQ_OUT && PM_CHANGE_ACK_IN; endsequence
  property p_req_rise; s_take ##0 CFG_PM_DSTATE_IN[0] |=> PM_CHANGE_REQ_OUT; endproperty
  a_req_rise: assert property (p_req_rise) else $error("request not raised");
  property p_no_req; s_take ##0 !CFG_PM_DSTATE_IN[0] |=> !PM_CHANGE_REQ_OUT; endproperty
  a_no_req: assert property (p_no_req) else $error("request for D0 or D2");
  property p_req_hold; PM_CHANGE_REQ_OUT && !PM_CHANGE_ACK_IN |=> PM_CHANGE_REQ_OUT; endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_hold; CFG_CPL_HOLD_OUT == PM_CHANGE_REQ_OUT; endproperty
  a_hold: assert property (p_hold) else $error("hold differs from request");
  property p_ext_fn; s_take ##0 CFG_PM_DSTATE_IN[0] |=> EXT_FUNC_NUM_OUT == $past(CFG_PM_FUNC_IN); endproperty
  a_ext_fn: assert property (p_ext_fn) else $error("wrong function number");
  property p_state_src;
    $changed(PF_DSTATE_OUT) |-> $past(PM_CHANGE_REQ_OUT && PM_CHANGE_ACK_IN) ||
      $past(CFG_PM_WR_IN && !PM_CHANGE_REQ_OUT && !CFG_PM_DSTATE_IN[0]);
  endproperty
  a_state_src: assert property (p_state_src) else $error("state changed without cause");
  property p_req_drop; s_ack |=> !PM_CHANGE_REQ_OUT && !CFG_CPL_HOLD_OUT; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
  property p_det_cause; ERR_COR_DET_OUT |-> $past(ERR_COR_IN || (|CORE_COR_ERR_IN)); endproperty
  a_det_cause: assert property (p_det_cause) else $error("detect without error");
  property p_msg_cause; ERR_COR_MSG_OUT |-> $past(ERR_COR_IN); endproperty
  a_msg_cause: assert property (p_msg_cause) else $error("message without user error");
endmodule

bind ppmce_ctrl ppmce_checker #(.NUM_PF(NUM_PF)) i_ppmce_checker (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .CFG_PM_WR_IN(CFG_PM_WR_IN),
  .CFG_PM_FUNC_IN(CFG_PM_FUNC_IN), .CFG_PM_DSTATE_IN(CFG_PM_DSTATE_IN),
  .CFG_CPL_HOLD_OUT(CFG_CPL_HOLD_OUT), .CORE_COR_ERR_IN(CORE_COR_ERR_IN),
  .PM_CHANGE_REQ_OUT(PM_CHANGE_REQ_OUT), .PM_CHANGE_ACK_IN(PM_CHANGE_ACK_IN),
  .EXT_FUNC_NUM_OUT(EXT_FUNC_NUM_OUT), .PF_DSTATE_OUT(PF_DSTATE_OUT), .ERR_COR_IN(ERR_COR_IN),
  .ERR_COR_DET_OUT(ERR_COR_DET_OUT), .ERR_COR_MSG_OUT(ERR_COR_MSG_OUT));

//--- sim/ppmce_user_model.sv
// User logic that acknowledges a power change after a chosen number of cycles.
module ppmce_user_model (
  input  wire logic       clk_in,   // Core clock.
  input  wire logic       rst_in,   // Reset, active high.
  input  wire logic       req_in,   // Change request from the block.
  input  wire logic [3:0] dly_in,   // Cycles to wait before acknowledging.
  output logic            ack_out   // One-cycle acknowledge.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;                // Cycles the request has stood.
  logic [3:0] cnt_d;                // Next count.
  logic       ack_d;                // Next acknowledge.
  // Count while the request stands, then pulse once and count again from zero.
  always_comb begin
    cnt_d = req_in ? cnt_q + 4'h1 : 4'h0;
    ack_d = 1'b0;
    if (ack_out) begin
      cnt_d = 4'h0;                 // No acknowledge in the cycle after one; the count restarts from zero.
    end else if (req_in && cnt_q == dly_in) begin
      ack_d = 1'b1;
      cnt_d = 4'h0;
    end
  end
  // Register the count and the acknowledge.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q   <= 4'h0;
      ack_out <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      ack_out <= ack_d;
    end
  end
endmodule

//--- sim/pcie_pm_and_corr_error_ctrl_tb_top.sv
// Drives registers, power writes and errors, and compares with a reference model.
module pcie_pm_and_corr_error_ctrl_tb_top import ppmce_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, rd, wr, pm_wr, pm_vf, err, ack, wreq, hold, req, det, msg, vf;
  logic [7:0]  addr, pm_fn, port, ext_fn, fn, pf_st, pf_m;
  logic [1:0]  pm_st, st;
  logic [31:0] wdata, rdata, q;
  logic [3:0]  core_err, dly, fen, ce;
  logic [15:0] vf_st, vf_m;
  int          n_mismatch, num_checks, seed, n;
  ppmce_ctrl i_ppmce_ctrl (.SYS_CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(wreq), .CFG_PM_WR_IN(pm_wr), .CFG_PM_FUNC_IN(pm_fn), .CFG_PM_IS_VF_IN(pm_vf),
    .CFG_PM_DSTATE_IN(pm_st), .CFG_CPL_HOLD_OUT(hold), .CORE_COR_ERR_IN(core_err),
    .PM_CHANGE_REQ_OUT(req), .PM_CHANGE_ACK_IN(ack), .EXT_FUNC_NUM_OUT(ext_fn), .PF_DSTATE_OUT(pf_st),
    .VF_DSTATE_OUT(vf_st), .LINK_CAP_PORT_NUM_IN(port), .ERR_COR_IN(err), .ERR_COR_DET_OUT(det),
    .ERR_COR_MSG_OUT(msg));
  ppmce_user_model i_ppmce_user_model (.clk_in(clk), .rst_in(rst), .req_in(req), .dly_in(dly),
    .ack_out(ack));
  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One Avalon access; holds the request until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    q = rdata;
    if (n >= 40) n_mismatch++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Reads a register and compares it.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Free-running 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
  // Main sequence.
  initial begin
    rst = 1'b1; rd = 1'b0; wr = 1'b0; pm_wr = 1'b0; pm_vf = 1'b0; err = 1'b0; addr = 8'h00;
    pm_fn = 8'h00; pm_st = 2'h0; wdata = 32'h0; core_err = 4'h0; dly = 4'h0; seed = 32'hFA11;
    port = 8'($random(seed)); pf_m = 8'h00; vf_m = 16'h0000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdchk(OFS_CTRL, {29'h0, CTRL_RESET});
    rdchk(OFS_FUNC_EN, 32'hF);
    rdchk(OFS_AER_COR, 32'h0);
    bus(1'b1, OFS_LINK_CAP, 32'h0);
    rdchk(OFS_LINK_CAP, {port, 24'h0});
    rdchk(8'h40, 32'h0);
    $display("register test done");
    // Every target state on PFs and VFs; D1 and D3 use acknowledge delays 1, 3, 5 and 7.
    for (int i = 0; i < 8; i++) begin
      vf = i[2];
      st = i[1:0];
      fn = vf ? 8'($random(seed) & 7) : 8'($random(seed) & 3);
      dly = 4'(i);
      @(posedge clk);
      pm_wr <= 1'b1;
      pm_vf <= vf;
      pm_fn <= fn;
      pm_st <= st;
      @(posedge clk);
      pm_wr <= 1'b0;
      #1;
      chk("req", 32'(st[0]), 32'(req));
      chk("hold", 32'(st[0]), 32'(hold));
      if (st[0]) chk("ext_fn", 32'(fn), 32'(ext_fn));
      n = 1;
      while (req === 1'b1 && n < 40) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("req_len", st[0] ? 32'(i + 3) : 32'h1, 32'(n));
      if (vf) vf_m[2*fn+:2] = st;
      else pf_m[2*fn+:2] = st;
      chk("pf_st", 32'(pf_m), 32'(pf_st));
      chk("vf_st", 32'(vf_m), 32'(vf_st));
    end
    $display("power test done");
    // Every control setting with user and core correctable errors.
    for (int k = 0; k < 8; k++) begin
      fen = (k == 5) ? 4'h0 : 4'($random(seed));
      bus(1'b1, OFS_CTRL, 32'(k));
      bus(1'b1, OFS_FUNC_EN, 32'(fen));
      @(posedge clk);
      err <= 1'b1;
      @(posedge clk);
      err <= 1'b0;
      #1;
      chk("det", 32'(k[0] && !k[2] && fen != 4'h0), 32'(det));
      chk("msg", 32'(k[1] && !k[2] && fen != 4'h0), 32'(msg));
      rdchk(OFS_AER_COR, 32'(fen));
      bus(1'b1, OFS_AER_COR, 32'hF);
      rdchk(OFS_AER_COR, 32'h0);
      ce = 4'($random(seed));
      @(posedge clk);
      core_err <= ce;
      @(posedge clk);
      core_err <= 4'h0;
      #1;
      chk("det_core", 32'(k[0] && (ce & fen) != 4'h0), 32'(det));
    end
    $display("error test done");
    test_done();
  end
endmodule
